// File: inc/acal_pkg.sv
/*
 * constants, encodings and state types shared by the calibration and host
 * interface logic of the sampling converter.
 * assumes one 100 MHz clock and an active-high asynchronous reset.
 */
package acal_pkg;
    // =====================================================================
    // control word fields
    localparam int BIT_CONV      = 0;
    localparam int BIT_CAL       = 1;
    localparam int BIT_RANGE     = 2;
    localparam int BIT_OVR       = 3;
    localparam int OP_LO         = 4;
    localparam int OP_HI         = 7;
    localparam int BIT_SLEEP     = 9;
    localparam int BIT_REFOFF    = 10;
    localparam int BIT_OFLOW     = 11;
    localparam int BIT_UFLOW     = 12;
    localparam int BIT_HALT      = 14;
    localparam int BIT_SRST      = 15;
    localparam logic [3:0] OP_DEFAULT = 4'h7;
    localparam logic [3:0] OP_RD_ALL  = 4'h8;
    localparam logic [3:0] OP_FULL_DEV = 4'hE;
    localparam logic [3:0] OP_FULL_SYS = 4'hF;
    // =====================================================================
    // coefficient store
    localparam int          COEF_WORDS = 40;
    localparam logic [5:0]  COEF_LAST  = 6'h27;
    localparam logic [5:0]  GAIN_BASE  = 6'h00;
    localparam logic [5:0]  OFFS_BASE  = 6'h14;
    // =====================================================================
    // timing: figures at the 10 MHz converter clock, scaled to 100 MHz
    localparam int CAL_MS        = 928;
    localparam int CLK_HZ        = 100_000_000;
    localparam int CAL_CYCLES    = CAL_MS * (CLK_HZ / 1000);
    localparam int PHASE_CYCLES  = CAL_CYCLES / 3;
    localparam int CONV_NS       = 2500;
    localparam int CONV_CYCLES   = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [15:0] FULL_POS = 16'hFFFF;
    localparam logic [15:0] ZERO_CODE = 16'h0000;

    typedef enum logic [2:0] {
        ACAL_IDLE,
        ACAL_DAC,
        ACAL_WAIT_OFS,
        ACAL_OFS,
        ACAL_WAIT_GAIN,
        ACAL_GAIN
    } acal_state_type;

    // decode helpers used by register and sequencer logic
    function automatic logic op_is_cal(input logic [3:0] op);
        return (op[3] == 1'b0 && op[2:1] != 2'b00) || (op[3:1] == 3'b111);
    endfunction

    function automatic logic op_is_sys(input logic [3:0] op);
        return op[0];
    endfunction
endpackage

// File: verilog/acal_coef_mem.sv
/*
 * forty-word coefficient store with registered read data.
 * assumes one clock; address is held in range by the caller.
 */
module acal_coef_mem
    import acal_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [5:0]  addr,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data
);
    logic [15:0] mem [0:COEF_WORDS-1];

    // =====================================================================
    // storage; no reset, contents come only from host coefficient writes
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // acal_coef_mem

// File: verilog/acal_sync2.sv
/*
 * two flip-flop synchroniser for a group of pin levels.
 * assumes inputs are asynchronous to clk.
 */
module acal_sync2
    import acal_pkg::*;
#(
    parameter int          W        = 1,
    parameter logic [W-1:0] INIT    = '0
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= INIT;
            q      <= INIT;
        end
        else
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // acal_sync2

// File: verilog/acal_host_if.sv
/*
 * calibration sequencer, conversion control and parallel host interface.
 * assumes host strobes are asynchronous pins; analog core supplies a result
 * with range status at core_done; data bus enable is active low.
 */
module acal_host_if
    import acal_pkg::*;
#(
    parameter int CAL_LEN   = PHASE_CYCLES,
    parameter int CONV_LEN  = CONV_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cal_req_n,
    input  wire logic        sync_mode_sel,
    input  wire logic        sample_trigger_n,
    input  wire logic        signed_range_sel,
    input  wire logic        sleep_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        register_select,
    input  wire logic [15:0] data_in,
    input  wire logic [15:0] core_result,
    input  wire logic        core_over,
    input  wire logic        core_under,
    output logic      [15:0] data_out,
    output logic             data_oe_n,
    output logic             busy_n,
    output logic             core_sleep,
    output logic             core_ref_off,
    output logic             core_bipolar
);
    // =====================================================================
    // pin synchronisers
    logic [8:0] pins_s;
    logic cal_s, ms_s, trig_s, rng_s, slp_s, cs_s, rd_s, wr_s, rs_s;

    // idle levels at reset: strobes and request high, mode and range low, so a
    // pin that rests high gives no false edge or conversion once reset lifts
    acal_sync2 #(.W(9), .INIT(9'h15F)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cal_req_n, sync_mode_sel, sample_trigger_n, signed_range_sel,
               sleep_n, cs_n, rd_n, wr_n, register_select}),
        .q   (pins_s)
    );
    assign {cal_s, ms_s, trig_s, rng_s, slp_s, cs_s, rd_s, wr_s, rs_s} = pins_s;

    // =====================================================================
    // state and next values
    acal_state_type state, next_state;
    logic [31:0] timer, next_timer;
    logic [15:0] conv_cnt, next_conv_cnt;
    logic        converting, next_converting;
    logic        cal_prev, trig_prev, wr_prev, rd_prev;
    logic        sys_cal, next_sys_cal;
    logic        range_r, next_range_r;
    logic        ovr, next_ovr;
    logic [3:0]  op, next_op;
    logic        sleep_r, next_sleep_r;
    logic        refoff_r, next_refoff_r;
    logic        oflow, next_oflow;
    logic        uflow, next_uflow;
    logic        halted, next_halted;
    logic        srst_n, next_srst_n;
    logic [15:0] result, next_result;
    logic [5:0]  caddr, next_caddr;
    logic        sync_run, next_sync_run;
    logic [15:0] next_data_out;
    logic        next_oe_n, next_busy_n;
    logic [15:0] coef_rd;
    logic        coef_we;
    logic [15:0] ctl_word;

    wire cal_rise  = cal_s & ~cal_prev;
    wire cal_fall  = ~cal_s & cal_prev;
    wire trig_fall = ~trig_s & trig_prev;
    wire wr_rise   = wr_s & ~wr_prev & ~cs_s;
    wire rd_rise   = rd_s & ~rd_prev & ~cs_s;
    wire coef_sel  = op[3] & ~(op[2] & op[1]);
    wire core_done = converting && conv_cnt == CONV_LEN[15:0] - 16'h0001;

    // effective controls: register wins when override set
    wire eff_range = ovr ? range_r : rng_s;
    wire eff_sleep = ovr ? ~sleep_r : ~slp_s;
    wire eff_refoff = ovr ? ~refoff_r : ~slp_s;

    // read view of the control word
    always_comb
    begin
        ctl_word = 16'h0000;
        ctl_word[BIT_CONV]   = converting;
        ctl_word[BIT_CAL]    = state != ACAL_IDLE;
        ctl_word[BIT_RANGE]  = eff_range;
        ctl_word[BIT_OVR]    = ovr;
        ctl_word[OP_HI:OP_LO] = op;
        ctl_word[BIT_SLEEP]  = ovr ? sleep_r : slp_s;
        ctl_word[BIT_REFOFF] = ovr ? refoff_r : slp_s;
        ctl_word[BIT_OFLOW]  = oflow;
        ctl_word[BIT_UFLOW]  = uflow;
        ctl_word[BIT_HALT]   = halted;
        ctl_word[BIT_SRST]   = srst_n;
    end

    // =====================================================================
    // next-state logic for register, sequencer and conversion
    always_comb
    begin
        next_state = state;
        next_timer = timer;
        next_conv_cnt = conv_cnt;
        next_converting = converting;
        next_sys_cal = sys_cal;
        next_range_r = range_r;
        next_ovr = ovr;
        next_op = op;
        next_sleep_r = sleep_r;
        next_refoff_r = refoff_r;
        next_oflow = oflow;
        next_uflow = uflow;
        next_halted = halted;
        next_srst_n = srst_n;
        next_result = result;
        next_caddr = caddr;
        next_sync_run = sync_run;
        coef_we = 1'b0;

        // register writes, taken at the write strobe's rising edge
        if (wr_rise && rs_s)
        begin
            if (!data_in[BIT_SRST])
            begin
                // soft reset: state, flags and controls to defaults, result and coefficient address kept; reset bit stays cleared
                next_state = ACAL_IDLE;
                next_converting = 1'b0;
                next_ovr = 1'b0;
                next_op = OP_DEFAULT;
                next_range_r = rng_s;
                next_sleep_r = slp_s;
                next_refoff_r = slp_s;
                next_oflow = 1'b0;
                next_uflow = 1'b0;
                next_halted = 1'b0;
                next_sync_run = 1'b0;
                next_srst_n = 1'b0;
            end
            else
            begin
                next_srst_n = 1'b1;
                next_ovr = data_in[BIT_OVR];
                next_range_r = data_in[BIT_RANGE];
                next_sleep_r = data_in[BIT_SLEEP];
                next_refoff_r = data_in[BIT_REFOFF];
                next_op = data_in[OP_HI:OP_LO];
                next_caddr = data_in[OP_HI-2] ? OFFS_BASE : GAIN_BASE;
                if (!data_in[BIT_HALT])
                begin
                    next_halted = 1'b0;
                end
                else if (state != ACAL_IDLE)
                begin
                    next_halted = 1'b1;
                end
                // software calibration only while the request pin rests high
                if (cal_s && srst_n && state == ACAL_IDLE &&
                    op_is_cal(data_in[OP_HI:OP_LO]))
                begin
                    next_state = ACAL_DAC;
                    next_sys_cal = op_is_sys(data_in[OP_HI:OP_LO]);
                    next_timer = 32'h0;
                end
            end
        end
        else if (wr_rise && coef_sel && srst_n)
        begin
            coef_we = op[0];
            next_caddr = (caddr == COEF_LAST) ? 6'h00 : caddr + 6'h01;
        end
        else if (rd_rise && !rs_s && coef_sel && !op[0])
        begin
            next_caddr = (caddr == COEF_LAST) ? 6'h00 : caddr + 6'h01;
        end

        // hardware requests: rising edge system, low pulse device, always full
        if (srst_n && state == ACAL_IDLE && (cal_rise || cal_fall))
        begin
            next_state = ACAL_DAC;
            next_sys_cal = cal_rise;
            next_timer = 32'h0;
            next_halted = 1'b0;
        end

        // sequencer; halt freezes the timer
        if (!halted && srst_n)
        begin
            unique case (state)
                ACAL_IDLE: ;
                ACAL_DAC, ACAL_OFS, ACAL_GAIN:
                begin
                    next_timer = timer + 32'h1;
                    if (timer == CAL_LEN - 1)
                    begin
                        next_timer = 32'h0;
                        unique case (state)
                            ACAL_DAC:  next_state = sys_cal ? ACAL_WAIT_OFS : ACAL_OFS;
                            ACAL_OFS:  next_state = sys_cal ? ACAL_WAIT_GAIN : ACAL_GAIN;
                            ACAL_GAIN:
                            begin
                                next_state = ACAL_IDLE;
                                next_sync_run = ms_s;
                            end
                            default:   next_state = ACAL_IDLE;
                        endcase
                    end
                end
                ACAL_WAIT_OFS:
                    if (trig_fall) next_state = ACAL_OFS;
                ACAL_WAIT_GAIN:
                    if (trig_fall) next_state = ACAL_GAIN;
            endcase
        end

        // conversions: per trigger, or back to back in synchronous mode
        if (state == ACAL_IDLE && srst_n && !eff_sleep)
        begin
            if (trig_fall && ms_s)
            begin
                next_sync_run = 1'b1;
            end
            if (!converting && (trig_fall || (ms_s && sync_run)))
            begin
                next_converting = 1'b1;
                next_conv_cnt = 16'h0;
            end
            else if (converting)
            begin
                next_conv_cnt = conv_cnt + 16'h1;
                if (core_done)
                begin
                    next_converting = 1'b0;
                    // clamp and flag out-of-range, code form follows range
                    next_oflow = core_over;
                    next_uflow = core_under;
                    next_result = core_over ? (eff_range ? 16'h7FFF : FULL_POS) :
                                  core_under ? (eff_range ? 16'h8000 : ZERO_CODE) :
                                  core_result;
                end
            end
        end
        if (!ms_s)
        begin
            next_sync_run = next_sync_run & ~sync_run;
        end
    end

    // output drivers: bus enabled only under chip select and read
    always_comb
    begin
        next_oe_n = ~(~cs_s & ~rd_s);
        next_busy_n = ~(state == ACAL_DAC || state == ACAL_OFS ||
                        state == ACAL_GAIN || converting);
        if (rs_s)
        begin
            next_data_out = ctl_word;
        end
        else if (coef_sel && !op[0])
        begin
            next_data_out = coef_rd;
        end
        else
        begin
            next_data_out = result;
        end
    end

    acal_coef_mem u_coef (
        .clk     (clk),
        .wr_en   (coef_we),
        .addr    (caddr),
        .wr_data (data_in),
        .rd_data (coef_rd)
    );

    // =====================================================================
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ACAL_IDLE;
            timer <= 32'h0;
            conv_cnt <= 16'h0;
            converting <= 1'b0;
            cal_prev <= 1'b1;
            trig_prev <= 1'b1;
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
            sys_cal <= 1'b0;
            range_r <= 1'b0;
            ovr <= 1'b0;
            op <= OP_DEFAULT;
            sleep_r <= 1'b1;
            refoff_r <= 1'b1;
            oflow <= 1'b0;
            uflow <= 1'b0;
            halted <= 1'b0;
            srst_n <= 1'b1;
            result <= 16'h0000;
            caddr <= 6'h00;
            sync_run <= 1'b1;                                // cleared on the first clock, as the mode pin synchroniser resets low
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
            busy_n <= 1'b1;
            core_sleep <= 1'b0;
            core_ref_off <= 1'b0;
            core_bipolar <= 1'b0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            conv_cnt <= next_conv_cnt;
            converting <= next_converting;
            cal_prev <= cal_s;
            trig_prev <= trig_s;
            wr_prev <= wr_s;
            rd_prev <= rd_s;
            sys_cal <= next_sys_cal;
            range_r <= next_range_r;
            ovr <= next_ovr;
            op <= next_op;
            sleep_r <= next_sleep_r;
            refoff_r <= next_refoff_r;
            oflow <= next_oflow;
            uflow <= next_uflow;
            halted <= next_halted;
            srst_n <= next_srst_n;
            result <= next_result;
            caddr <= next_caddr;
            sync_run <= next_sync_run;
            data_out <= next_data_out;
            data_oe_n <= next_oe_n;
            busy_n <= next_busy_n;
            core_sleep <= eff_sleep;
            core_ref_off <= eff_refoff;
            core_bipolar <= eff_range;
        end
    end

    // =====================================================================
    // checks
    a_bus_enable: assert property (@(posedge clk) disable iff (rst)
        (!cs_s && !rd_s) |=> !data_oe_n)
        else $error("data bus not enabled under read");
    a_bus_release: assert property (@(posedge clk) disable iff (rst)
        (cs_s || rd_s) |=> data_oe_n)
        else $error("data bus driven without read");
    a_wait_offset: assert property (@(posedge clk) disable iff (rst)
        (state == ACAL_WAIT_OFS && !trig_fall) |=> state == ACAL_WAIT_OFS)
        else $error("offset phase left without trigger");
    a_wait_gain: assert property (@(posedge clk) disable iff (rst)
        (state == ACAL_WAIT_GAIN && !trig_fall) |=> state == ACAL_WAIT_GAIN)
        else $error("gain phase left without trigger");
    a_sys_start: assert property (@(posedge clk) disable iff (rst)
        (cal_rise && state == ACAL_IDLE && srst_n) |=> state == ACAL_DAC && sys_cal)
        else $error("system calibration not started");
    a_busy_wait: assert property (@(posedge clk) disable iff (rst)
        (state == ACAL_WAIT_OFS && !converting) |=> busy_n)
        else $error("busy low while waiting for trigger");
    a_cal_flag: assert property (@(posedge clk) disable iff (rst)
        ctl_word[BIT_CAL] == (state != ACAL_IDLE))
        else $error("calibration flag mismatch");
    a_range_pin: assert property (@(posedge clk) disable iff (rst)
        !ovr |-> ctl_word[BIT_RANGE] == rng_s)
        else $error("range bit not following pin");
    a_soft_reset: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && rs_s && !data_in[BIT_SRST]) |=> op == OP_DEFAULT && !srst_n)
        else $error("soft reset did not restore defaults");
    a_flags_done: assert property (@(posedge clk) disable iff (rst)
        (core_done && state == ACAL_IDLE && srst_n && !eff_sleep)
        |=> oflow == $past(core_over) && uflow == $past(core_under))
        else $error("range flags not captured");
endmodule // acal_host_if

// File: tb/acal_host_model.sv
/* host processor model driving the parallel bus strobes.
   assumes its task is called just after a falling clock edge. */
module acal_host_model
    import acal_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe_n,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             register_select,
    output logic [15:0]      data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus idle at time zero
    initial
    begin
        {cs_n, rd_n, wr_n, register_select} = 4'hF;
        data_in = 16'h0000;
    end
    // strobe held five cycles, other levels four, above the three-cycle minimum
    task automatic access(input logic sel, input logic wr, input logic [15:0] wd,
                          output logic [15:0] rdv);
        register_select = sel;
        data_in = wd;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (5) @(negedge clk);
        // sampled on a discrete strobe, never on a tied-low bus
        rdv = (data_oe_n === 1'b0) ? data_out : 'x;
        {rd_n, wr_n} = 2'b11;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        data_in = ~wd; // released bus shows no stale value
        repeat (4) @(negedge clk);
    endtask
endmodule // acal_host_model

// File: tb/adc_calibration_host_interface_tb.sv
/* self-checking bench for the calibration and host interface block.
   assumes short phase and conversion lengths set at the instance. */
module adc_calibration_host_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import acal_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cal_req_n = 1'b1;
    logic        sync_mode_sel = 1'b0;
    logic        sample_trigger_n = 1'b1;
    logic        signed_range_sel = 1'b0;
    logic        sleep_n = 1'b1;
    logic [15:0] core_result = 16'h1234;
    logic        core_over = 1'b0;
    logic        core_under = 1'b0;
    logic        cs_n, rd_n, wr_n, register_select, data_oe_n, busy_n;
    logic        core_sleep, core_ref_off, core_bipolar;
    logic [15:0] data_in, data_out, rv;
    int          err_total = 0;
    int          total_checks = 0;
    int          falls = 0;
    int          f0;
    acal_host_if #(.CAL_LEN(20), .CONV_LEN(8)) u_acal_host_if (
        .clk              (clk),
        .rst              (rst),
        .cal_req_n        (cal_req_n),
        .sync_mode_sel    (sync_mode_sel),
        .sample_trigger_n (sample_trigger_n),
        .signed_range_sel (signed_range_sel),
        .sleep_n          (sleep_n),
        .cs_n             (cs_n),
        .rd_n             (rd_n),
        .wr_n             (wr_n),
        .register_select  (register_select),
        .data_in          (data_in),
        .core_result      (core_result),
        .core_over        (core_over),
        .core_under       (core_under),
        .data_out         (data_out),
        .data_oe_n        (data_oe_n),
        .busy_n           (busy_n),
        .core_sleep       (core_sleep),
        .core_ref_off     (core_ref_off),
        .core_bipolar     (core_bipolar)
    );
    acal_host_model u_acal_host_model (
        .clk             (clk),
        .data_out        (data_out),
        .data_oe_n       (data_oe_n),
        .cs_n            (cs_n),
        .rd_n            (rd_n),
        .wr_n            (wr_n),
        .register_select (register_select),
        .data_in         (data_in)
    );
    always #5 clk = ~clk;
    always @(negedge busy_n) falls++;
    // ====================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bounded wait; running out ends the run
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; n < lim && busy_n !== lvl; n++)
            @(negedge clk);
        if (busy_n !== lvl)
        begin
            check({15'h0, busy_n}, {15'h0, lvl});
            finish_test;
        end
    endtask
    task automatic wr(input logic sel, input logic [15:0] v);
        u_acal_host_model.access(sel, 1'b1, v, rv);
    endtask
    task automatic rd(input logic sel);
        u_acal_host_model.access(sel, 1'b0, 16'h0000, rv);
    endtask
    task automatic trig;
        sample_trigger_n = 1'b0;
        repeat (4) @(negedge clk);
        sample_trigger_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // ====================
    // test sequence
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rd(1'b1);
        check(rv & 16'hDEFF, 16'h8670);
        signed_range_sel = 1'b1;
        repeat (4) @(negedge clk);
        rd(1'b1);
        check({15'h0, rv[2]}, 16'h0001);
        wr(1'b1, 16'h8608);
        rd(1'b1);
        check(rv & 16'hDEFC, 16'h8608);
        check({15'h0, core_bipolar}, 16'h0000);
        wr(1'b1, 16'h840C);
        check({13'h0, core_sleep, core_ref_off, core_bipolar}, 16'h0005);
        wr(1'b1, 16'h820C);
        check({14'h0, core_sleep, core_ref_off}, 16'h0001);
        wr(1'b1, 16'h0000);
        rd(1'b1);
        check(rv & 16'hDEFF, 16'h0674);
        wr(1'b1, 16'h8000);
        $display("test register bits done");
        f0 = falls;
        trig;
        repeat (30) @(negedge clk);
        check(16'(falls - f0), 16'h0001);
        rd(1'b0);
        check(rv, 16'h1234);
        check({15'h0, data_oe_n}, 16'h0001);
        // over then under range flags
        for (int i = 1; i < 3; i++)
        begin
            {core_under, core_over} = 2'(i);
            trig;
            repeat (30) @(negedge clk);
            rd(1'b1);
            check({14'h0, rv[12:11]}, 16'(i));
        end
        {core_under, core_over} = 2'b00;
        $display("test conversion done");
        wr(1'b1, 16'h8090);
        for (int i = 0; i < 40; i++)
            wr(1'b0, 16'hC000 + 16'(i));
        wr(1'b1, 16'h8080);
        for (int i = 0; i < 40; i++)
        begin
            rd(1'b0);
            check(rv, 16'hC000 + 16'(i));
        end
        wr(1'b1, 16'h8000);
        $display("test coefficients done");
        // falling edge runs a device calibration first
        cal_req_n = 1'b0;
        repeat (150) @(negedge clk);
        f0 = falls;
        cal_req_n = 1'b1;
        wait_busy(1'b0, 8);
        wait_busy(1'b1, 40);
        rd(1'b1);
        check({15'h0, rv[1]}, 16'h0001);
        repeat (30) @(negedge clk);
        core_result = 16'h0000; // zero input before the trigger
        check(16'(falls - f0), 16'h0001);
        trig;
        wait_busy(1'b1, 40);
        repeat (30) @(negedge clk);
        check(16'(falls - f0), 16'h0002);
        core_result = 16'hFFFF; // full scale before the trigger
        trig;
        wait_busy(1'b1, 40);
        check(16'(falls - f0), 16'h0003);
        rd(1'b1);
        check({15'h0, rv[1]}, 16'h0000);
        $display("test system calibration done");
        sync_mode_sel = 1'b1;
        trig;
        for (int i = 0; i < 3; i++)
        begin
            core_result = 16'h5A00 + 16'(i);
            repeat (30) @(negedge clk);
            rd(1'b0);
            check(rv, 16'h5A00 + 16'(i));
        end
        $display("test synchronous done");
        finish_test;
    end
endmodule // adc_calibration_host_interface_tb
